// *** fftf_pkg.sv ***
// Shared constants, types and register map of the transform frame interface.
package fftf_pkg;
  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int IN_W = 16;
  localparam int LOG2N_DEF = 10;
  localparam int LOG2N_MAX = 16;
  localparam int LOG2N_MIN = 3;
  localparam int LOG2N_R4_MIN = 6;
  localparam int LOG2N_R4S_MAX = 13;
  localparam int OUT_W = IN_W + 1 + LOG2N_MAX;
  localparam int NFFT_W = 5;
  localparam int SCH_W_MAX = 2 * LOG2N_MAX;
  localparam int SHIFT_W = 6;
  localparam int EXP_W = 4;
  localparam int TW_W_DEF = 16;
  localparam int PROC_LAT_DEF = 8;
  localparam logic [EXP_W-1:0] BLK_EXP_NONE = 4'h0;
  // ----------------------------------------------------------------
  // Build options
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ARCH_R4_STREAM = 2'h0,
    ARCH_R4_BURST = 2'h1,
    ARCH_R2_MIN = 2'h2,
    ARCH_PIPE_STREAM = 2'h3
  } fftf_arch_t;
  localparam logic [1:0] SCL_UNSCALED = 2'h0;
  localparam logic [1:0] SCL_SCALED = 2'h1;
  localparam logic [1:0] SCL_BFP = 2'h2;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_NAT = 0;
  localparam int CTRL_SCL_LO = 1;
  localparam int CTRL_CONV = 3;
  localparam int CTRL_DYN = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam int ST_BUSY = 0;
  localparam int ST_RFD = 1;
  localparam int ST_OVF = 2;
  localparam int ST_FWD = 3;
  localparam int ST_CFG_OK = 4;
  localparam int ST_EXP_LO = 8;
  localparam int ST_LOG2_LO = 16;
  // ----------------------------------------------------------------
  // Sample carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [IN_W-1:0] re;
    logic signed [IN_W-1:0] im;
  } fftf_in_t;
  typedef struct packed {
    logic signed [OUT_W-1:0] re;
    logic signed [OUT_W-1:0] im;
  } fftf_out_t;
endpackage

// *** fftf_frame.sv ***
// Frame sequencing, sample store, unload ordering and control registers of the transform block.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Scaled keeps input width; unscaled grows.
// - Input and output positions, log2 N wide.
// - Ready-for-data from start to last position.
// - Busy while the frame is computed.
// - Output-valid marks each valid output sample.
// - Early done one cycle before done.
// - Done when output frame is ready.
// - Scaled mode overflow flag per frame.
// - Four-bit block exponent in block-float mode; blk_exp is always held at BLK_EXP_NONE.
// - One of four architectures at build.
// - Power-of-two length, per-architecture limits.
// - Natural or bit-reversed output order.
// - Three formats; no block-float for streaming.
// - Truncation or convergent rounding per rank.
// - Twiddle width 8, 12, 16, 20 or 24.
// - Burst unload natural; start first bit-reversed.
// - Direction 1 forward, 0 inverse; forward default.
// - Direction strobe applies to next frame.
// - Schedule strobe applies to next frame.
// - Size strobe aborts and loads new size.
module fftf_frame import fftf_pkg::*; #(
  parameter fftf_arch_t ARCH = ARCH_R2_MIN,
  parameter int LOG2N = LOG2N_DEF,
  parameter int TW_W = TW_W_DEF,
  parameter int PROC_LAT = PROC_LAT_DEF,
  parameter bit OVF_PORT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start,
  input wire logic unload,
  input wire logic fwd,
  input wire logic fwd_we,
  input wire logic [SCH_W_MAX-1:0] scale_sch,
  input wire logic scale_sch_we,
  input wire logic [NFFT_W-1:0] nfft,
  input wire logic nfft_we,
  input wire fftf_in_t in_sample,
  output fftf_out_t out_sample,
  output logic [LOG2N-1:0] in_sample_position,
  output logic [LOG2N-1:0] out_sample_position,
  output logic rfd,
  output logic busy,
  output logic vout,
  output logic edone,
  output logic done,
  output logic ovflo,
  output logic [EXP_W-1:0] blk_exp
);
  // ----------------------------------------------------------------
  // Build-time legality
  // ----------------------------------------------------------------
  localparam int NPTS = 1 << LOG2N;
  localparam bit IS_R2 = (ARCH == ARCH_R2_MIN);
  localparam bit IS_BURST = (ARCH == ARCH_R4_BURST) || IS_R2;
  localparam int SCH_W = IS_R2 ? 2 * LOG2N : 2 * ((LOG2N + 1) / 2);
  localparam int LMIN = (ARCH == ARCH_R4_STREAM || ARCH == ARCH_R4_BURST) ? LOG2N_R4_MIN : LOG2N_MIN;
  localparam int LMAX = (ARCH == ARCH_R4_STREAM) ? LOG2N_R4S_MAX : LOG2N_MAX;
  localparam bit CFG_OK = (LOG2N >= LMIN) && (LOG2N <= LMAX) &&
    (TW_W == 8 || TW_W == 12 || TW_W == 16 || TW_W == 20 || TW_W == 24) && (PROC_LAT >= 2);
  localparam logic [NFFT_W-1:0] LOG2_RST = NFFT_W'(LOG2N);
  localparam logic [NFFT_W-1:0] LOG2_LO = NFFT_W'(LMIN);

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_PROC, S_WAIT, S_UNLOAD} fftf_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [LOG2N-1:0] fftf_addr(input logic [LOG2N-1:0] i, input logic nat,
                                                 input logic [NFFT_W-1:0] lg);
    logic [LOG2N-1:0] r;
    r = '0;
    for (int b = 0; b < LOG2N; b++) begin
      r[b] = i[LOG2N-1-b];
    end
    return nat ? i : LOG2N'(r >> (NFFT_W'(LOG2N) - lg));
  endfunction

  function automatic logic [SHIFT_W-1:0] fftf_shift(input logic [SCH_W_MAX-1:0] s);
    logic [SHIFT_W-1:0] t;
    t = '0;
    for (int k = 0; k < SCH_W / 2; k++) begin
      t = t + SHIFT_W'(s[2*k +: 2]);
    end
    return (t > SHIFT_W'(IN_W - 1)) ? SHIFT_W'(IN_W - 1) : t;
  endfunction

  function automatic logic signed [OUT_W-1:0] fftf_scale(input logic signed [IN_W-1:0] x,
                                                         input logic [SHIFT_W-1:0] s, input logic conv);
    logic signed [IN_W:0] q;
    logic [IN_W-1:0] rem;
    logic [IN_W-1:0] half;
    logic up;
    q = {x[IN_W-1], x} >>> s;
    rem = x & ((IN_W'(1) << s) - IN_W'(1));
    half = (s == '0) ? '0 : (IN_W'(1) << (s - SHIFT_W'(1)));
    up = conv && (s != '0) && ((rem > half) || ((rem == half) && q[0]));
    q = q + (IN_W + 1)'(up);
    return OUT_W'(q);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fftf_state_t state, next_state;
  logic [CTRL_W-1:0] ctrl;
  logic [NFFT_W-1:0] cur_log2;
  logic fwd_pend, fwd_cur;
  logic [SCH_W_MAX-1:0] sch_pend, sch_cur;
  logic [LOG2N-1:0] wr_cnt, rd_cnt;
  logic [$clog2(PROC_LAT+1)-1:0] proc_cnt;
  logic unl_nat, ovf_acc;
  fftf_in_t mem [NPTS];

  wire [1:0] scl_mode = ctrl[CTRL_SCL_LO +: 2];
  wire [1:0] scl_eff = (scl_mode == SCL_BFP && !IS_BURST) ? SCL_SCALED : scl_mode;
  wire dyn_load = nfft_we && ctrl[CTRL_DYN];
  wire [LOG2N-1:0] last_pos = LOG2N'((NPTS - 1) >> (NFFT_W'(LOG2N) - cur_log2));
  wire [SHIFT_W-1:0] sh_amt = fftf_shift(sch_cur);
  wire [NFFT_W-1:0] nfft_clamp = (nfft < LOG2_LO) ? LOG2_LO : (nfft > LOG2_RST) ? LOG2_RST : nfft;
  wire in_last = (wr_cnt == last_pos);
  wire out_last = (rd_cnt == last_pos);
  wire proc_end = (proc_cnt == ($bits(proc_cnt))'(PROC_LAT - 1));
  wire [LOG2N-1:0] rd_addr = fftf_addr(rd_cnt, unl_nat, cur_log2);
  wire in_neg_max = (in_sample.re == {1'b1, {(IN_W-1){1'b0}}}) || (in_sample.im == {1'b1, {(IN_W-1){1'b0}}});
  wire ovf_hit = (scl_eff == SCL_SCALED) && (sh_amt == '0) && in_neg_max;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (start) next_state = S_LOAD;
      S_LOAD: if (in_last) next_state = S_PROC;
      S_PROC: if (proc_end) next_state = IS_BURST ? S_WAIT : S_UNLOAD;
      S_WAIT: if (unload || start) next_state = S_UNLOAD;
      S_UNLOAD: if (out_last) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
    if (dyn_load) next_state = S_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      wr_cnt <= '0;
      rd_cnt <= '0;
      proc_cnt <= '0;
    end else begin
      state <= next_state;
      wr_cnt <= (state == S_LOAD && !in_last && !dyn_load) ? wr_cnt + LOG2N'(1) : '0;
      rd_cnt <= (state == S_UNLOAD && !out_last && !dyn_load) ? rd_cnt + LOG2N'(1) : '0;
      proc_cnt <= (state == S_PROC && !proc_end) ? proc_cnt + 1'b1 : '0;
    end
  end

  always_ff @(posedge pclk) begin
    if (state == S_LOAD) begin
      mem[wr_cnt] <= in_sample;
    end
  end

  // ----------------------------------------------------------------
  // Per-frame settings
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_pend <= 1'b1;
      fwd_cur <= 1'b1;
      sch_pend <= '0;
      sch_cur <= '0;
      cur_log2 <= LOG2_RST;
      unl_nat <= 1'b0;
      ovf_acc <= 1'b0;
    end else begin
      if (fwd_we) fwd_pend <= fwd;
      if (scale_sch_we && scl_eff == SCL_SCALED) sch_pend <= scale_sch;
      if (state == S_IDLE && start) begin
        fwd_cur <= fwd_we ? fwd : fwd_pend;
        sch_cur <= (scale_sch_we && scl_eff == SCL_SCALED) ? scale_sch : sch_pend;
      end
      if (dyn_load) cur_log2 <= nfft_clamp;
      if (state == S_PROC && proc_end) unl_nat <= IS_BURST ? 1'b0 : ctrl[CTRL_NAT];
      else if (state == S_WAIT && unload) unl_nat <= 1'b1;
      if (state == S_IDLE) ovf_acc <= 1'b0;
      else if (state == S_LOAD && ovf_hit) ovf_acc <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // The store is read at the natural or bit-reversed address rd_addr; data leave one cycle after the address is formed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sample <= '0;
      out_sample_position <= '0;
      vout <= 1'b0;
      ovflo <= 1'b0;
      blk_exp <= BLK_EXP_NONE;
    end else begin
      vout <= (state == S_UNLOAD) && !dyn_load;
      if (state == S_UNLOAD) begin
        out_sample.re <= (scl_eff == SCL_UNSCALED) ? OUT_W'(mem[rd_addr].re) :
                         fftf_scale(mem[rd_addr].re, sh_amt, ctrl[CTRL_CONV]);
        out_sample.im <= (scl_eff == SCL_UNSCALED) ? OUT_W'(mem[rd_addr].im) :
                         fftf_scale(mem[rd_addr].im, sh_amt, ctrl[CTRL_CONV]);
        out_sample_position <= rd_addr;
      end
      if (done) begin
        ovflo <= OVF_PORT && ovf_acc;
        blk_exp <= BLK_EXP_NONE;
      end
    end
  end

  assign in_sample_position = wr_cnt;
  assign rfd = (state == S_LOAD);
  assign busy = (state == S_PROC);
  assign edone = busy && (proc_cnt == ($bits(proc_cnt))'(PROC_LAT - 2));
  assign done = busy && proc_end;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states keep the bus simple; reads show live status, so no read side effects exist.
  wire acc = psel && penable;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_stat = (paddr == REG_STAT);
  wire [31:0] stat_word = (32'(busy) << ST_BUSY) | (32'(rfd) << ST_RFD) | (32'(ovflo) << ST_OVF) |
    (32'(fwd_cur) << ST_FWD) | (32'(CFG_OK) << ST_CFG_OK) | (32'(blk_exp) << ST_EXP_LO) |
    (32'(cur_log2) << ST_LOG2_LO);
  assign pready = 1'b1;
  assign pslverr = acc && !hit_ctrl && !hit_stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      prdata <= '0;
    end else begin
      if (acc && pwrite && hit_ctrl) ctrl <= pwdata[CTRL_W-1:0];
      if (psel && !penable && !pwrite) prdata <= hit_ctrl ? 32'(ctrl) : hit_stat ? stat_word : '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_rfd_span: assert property (rfd && in_last && !dyn_load |=> !rfd && busy)
    else $error("ready-for-data not dropped after last input");
  chk_in_count: assert property (rfd && $past(rfd) |-> in_sample_position == $past(in_sample_position) + 1'b1)
    else $error("input position did not advance");
  chk_busy_done: assert property (done |-> busy && !$past(done))
    else $error("done outside busy");
  chk_edone_lead: assert property (edone && !dyn_load |=> done)
    else $error("done did not follow early done");
  chk_done_ready: assert property (done && !IS_BURST && !dyn_load |=> ##1 vout)
    else $error("output not delivered after done");
  chk_vout_src: assert property (vout |-> $past(state) == S_UNLOAD)
    else $error("valid without unload");
  chk_fwd_hold: assert property (state != S_IDLE |=> fwd_cur == $past(fwd_cur))
    else $error("direction changed mid-frame");
  chk_sch_hold: assert property (state != S_IDLE |=> sch_cur == $past(sch_cur))
    else $error("schedule changed mid-frame");
  chk_ovf_mode: assert property (ovflo |-> scl_eff == SCL_SCALED)
    else $error("overflow outside scaled mode");
  chk_abort_size: assert property (dyn_load |=> state == S_IDLE && cur_log2 == $past(nfft_clamp))
    else $error("size strobe did not abort");
  chk_unload_nat: assert property (state == S_WAIT && unload |=> unl_nat && state == S_UNLOAD)
    else $error("unload did not select natural order");
  chk_keep_width: assert property (vout && scl_eff != SCL_UNSCALED |->
    (&out_sample.re[OUT_W-1:IN_W-1]) || !(|out_sample.re[OUT_W-1:IN_W-1]))
    else $error("scaled output exceeds input width");

  cov_frame: cover property (rfd && in_last ##1 busy ##1 busy);
  cov_unload_nat: cover property (state == S_WAIT && unload);
  cov_start_rev: cover property (state == S_WAIT && start && !unload);
  cov_abort: cover property (dyn_load && state == S_LOAD);
endmodule // fftf_frame

// *** fftf_stream_model.sv ***
// Upstream sample source and unload requester facing the transform block.
`timescale 1ns/1ps
module fftf_stream_model import fftf_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic nat,
  input wire logic [IN_W-1:0] base,
  input wire logic rfd,
  input wire logic done,
  output logic start,
  output logic unload,
  output fftf_in_t in_sample
);
  logic [IN_W-1:0] k;
  logic [IN_W-1:0] val;
  assign val = base + k;
  // signed fraction samples.
  // Outside load cycles the lines carry the inverse, so a stale sample cannot pass.
  assign in_sample.re = rfd ? val : ~val;
  assign in_sample.im = rfd ? -val : val;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k <= '0;
      start <= 1'b0;
      unload <= 1'b0;
    end else begin
      start <= go | (done & ~nat);
      unload <= done & nat;
      if (go) begin
        k <= '0;
      end else if (rfd) begin
        k <= k + 1'b1;
      end
    end
  end
endmodule // fftf_stream_model

// *** testbench.sv ***
// Self-checking bench for the transform frame interface.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module testbench import fftf_pkg::*;;
  localparam int LG = 3;
  localparam int N = 8;
  localparam int PL = 2;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} fftf_row_t;
  fftf_row_t rows [6] = '{'{REG_STAT, 1'h0, 32'h0, 32'h00030018, 1'h0}, '{REG_CTRL, 1'h1, 32'hffffffff, 32'h0, 1'h0},
    '{REG_CTRL, 1'h0, 32'h0, 32'h0000001f, 1'h0}, '{8'h08, 1'h0, 32'h0, 32'h0, 1'h1},
    '{8'h0c, 1'h1, 32'h5, 32'h0, 1'h1}, '{REG_CTRL, 1'h1, 32'h0, 32'h0, 1'h0}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, start, unload, rfd, busy, vout, edone, done, ovflo, e;
  logic fwd = 1'b1, fwd_we = 1'b0, scale_sch_we = 1'b0, go = 1'b0, nat = 1'b0;
  logic [SCH_W_MAX-1:0] scale_sch = '0;
  logic [IN_W-1:0] base = '0;
  logic [EXP_W-1:0] blk_exp;
  logic [LG-1:0] in_pos, out_pos;
  fftf_in_t in_sample;
  fftf_out_t out_sample;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  always #25 pclk = ~pclk;
  fftf_frame #(.LOG2N(LG), .PROC_LAT(PL)) u_fftf_frame (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start(start), .unload(unload), .fwd(fwd), .fwd_we(fwd_we), .scale_sch(scale_sch),
    .scale_sch_we(scale_sch_we), .nfft(5'h03), .nfft_we(1'b0), .in_sample(in_sample), .out_sample(out_sample),
    .in_sample_position(in_pos), .out_sample_position(out_pos), .rfd(rfd), .busy(busy), .vout(vout),
    .edone(edone), .done(done), .ovflo(ovflo), .blk_exp(blk_exp));
  fftf_stream_model u_fftf_stream_model (.pclk(pclk), .presetn(presetn), .go(go), .nat(nat), .base(base),
    .rfd(rfd), .done(done), .start(start), .unload(unload), .in_sample(in_sample));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang costs a mismatch; the whole run needs well under a thousand cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from driving psel twice in one step.
    @(posedge pclk);
  endtask
  task automatic frame(input logic nm, input logic [IN_W-1:0] b, input logic cv, input logic ov);
    int k, i, ed, dn;
    logic [IN_W-1:0] v;
    logic [LG-1:0] x;
    nat <= nm;
    base <= b;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (i = 0; i < 8 && rfd !== 1'b1; i++) @(posedge pclk);
    for (k = 0; k < 20 && rfd === 1'b1; k++) begin
      `CHK("in_pos", LG'(k), in_pos)
      @(posedge pclk);
    end
    `CHK("rfd_len", N, k)
    ed = -1;
    dn = -1;
    for (i = 0; i < 20 && busy === 1'b1; i++) begin
      if (edone === 1'b1) ed = i;
      if (done === 1'b1) dn = i;
      @(posedge pclk);
    end
    `CHK("busy_len", PL, i)
    `CHK("done_at", PL - 1, dn)
    `CHK("edone_at", dn - 1, ed)
    for (i = 0; i < 10 && vout !== 1'b1; i++) @(posedge pclk);
    for (k = 0; k < N; k++) begin
      x = LG'(k);
      `CHK("vout", 1'b1, vout)
      `CHK("out_pos", nm ? x : {x[0], x[1], x[2]}, out_pos)
      v = b + IN_W'(out_pos);
      if (cv) `CHK("out_re", OUT_W'(signed'(v)), out_sample.re)
      `CHK("ovflo", ov, ovflo)
      @(posedge pclk);
    end
    `CHK("vout_end", 1'b0, vout)
    `CHK("blk_exp", BLK_EXP_NONE, blk_exp)
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("rfd_rst", 1'b0, rfd)
    `CHK("busy_rst", 1'b0, busy)
    `CHK("vout_rst", 1'b0, vout)
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) `CHK("rdata", rows[i].q, q)
      `CHK("slverr", rows[i].e, e)
    end
    fwd <= 1'b0;
    fwd_we <= 1'b1;
    @(posedge pclk);
    fwd_we <= 1'b0;
    apb(REG_STAT, 1'b0, 32'h0);
    `CHK("fwd_pend", 1'b1, q[ST_FWD])
    frame(1'b1, 16'h0010, 1'b1, 1'b0);
    apb(REG_STAT, 1'b0, 32'h0);
    `CHK("fwd_used", 1'b0, q[ST_FWD])
    frame(1'b0, 16'h8000, 1'b1, 1'b0);
    apb(REG_CTRL, 1'b1, 32'(SCL_SCALED) << CTRL_SCL_LO);
    scale_sch_we <= 1'b1;
    @(posedge pclk);
    scale_sch_we <= 1'b0;
    frame(1'b1, 16'h8000, 1'b0, 1'b1);
    complete_run();
  end
endmodule // testbench
